// ---- sam_arb.v ----
// Bus arbiter with fixed or round-robin priority, index 0 lowest
`timescale 1ns/1ps
module sam_arb #(
    parameter N = 4
) (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_rst_n,
    // Control
    input  wire         i_rotate,
    input  wire         i_xfer_done,
    // Masters
    input  wire [N-1:0] i_req,
    output wire [N-1:0] o_gnt
);
    reg  [N-1:0] gnt_q;
    reg  [N-1:0] gnt_d;
    reg  [N-1:0] last_q;
    integer      k;
    integer      idx;
    reg          found;

    // Owner keeps the bus until its transfer ends or it lets go
    wire free = (gnt_q == {N{1'b0}}) | i_xfer_done | ((gnt_q & i_req) == {N{1'b0}});

    always @* begin
        gnt_d = gnt_q;
        found = 1'b0;
        idx   = 0;
        k     = 0;
        if (free) begin
            gnt_d = {N{1'b0}};
            if (i_rotate) begin
                // Search upward from the one after the last owner
                for (k = 1; k <= N; k = k + 1) begin
                    for (idx = 0; idx < N; idx = idx + 1) begin
                        if (!found && last_q[idx] && i_req[(idx + k) % N]) begin
                            gnt_d[(idx + k) % N] = 1'b1;
                            found = 1'b1;
                        end
                    end
                end
            end else begin
                for (k = 0; k < N; k = k + 1) begin
                    if (i_req[k]) begin
                        gnt_d = {N{1'b0}};
                        gnt_d[k] = 1'b1;
                    end
                end
            end
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            gnt_q  <= {N{1'b0}};
            last_q <= {{(N-1){1'b0}}, 1'b1};
        end else begin
            gnt_q <= gnt_d;
            if (gnt_d != {N{1'b0}}) begin
                last_q <= gnt_d;
            end
        end
    end

    assign o_gnt = gnt_q;
endmodule

// ---- sam_consts.vh ----
// Constants for the system address map, external address generator and arbiter
// Contract
// - 0x0000_0000-0x7FFF_FFFF goes to external memory
// - 0xB000_0000-0xBBFF_FFFF peripherals, rest reserved
// - 0x8000_0000-0xAFFF_FFFF shadows external 0-0x2FFF_FFFF
// - Low window: control, clock, 4 KB blocks
// - High window: serial ports 256 B, others 4 KB
// - SDRAM banks placed by programmed base, size
// - Bank start is 13-bit base shifted 18
// - Boot fetch address is zero after reset
// - Access outside every bank signals abort
// - IO bank 4/8/16 MB, SDRAM 128 MB
// - Align bit 0: pins shifted by width
// - Align bit 1: pins unshifted, 4 MB cap
// - Fixed or rotating mode per bus
// - Fixed mode grants highest requesting priority
// - Priority order per bus, lowest first
// - Rotating mode grants round robin
`ifndef SAM_CONSTS_VH
`define SAM_CONSTS_VH
// Address map
`define SAM_EXT_LAST      32'h7FFF_FFFF
`define SAM_SHADOW_BASE   32'h8000_0000
`define SAM_SHADOW_LAST   32'hAFFF_FFFF
`define SAM_PERI_BASE     32'hB000_0000
`define SAM_PERI_LAST     32'hBBFF_FFFF
`define SAM_HIGH_BASE     32'hB800_0000
`define SAM_GCR_LAST      32'hB000_01FF
`define SAM_CLK_BASE      32'hB000_0200
`define SAM_CLK_LAST      32'hB000_02FF
`define SAM_BOOT_ADDR     32'h0000_0000
// Peripheral select codes, zero means none
`define SAM_PS_NONE       5'h00
`define SAM_PS_GCR        5'h01
`define SAM_PS_CLK        5'h02
`define SAM_PS_EBUS       5'h0F
// Config register offsets
`define SAM_REG_ARB       8'h00
`define SAM_REG_SD0       8'h04
`define SAM_REG_SD1       8'h08
`define SAM_REG_IO0       8'h0C
`define SAM_REG_IO1       8'h10
`define SAM_REG_IO2       8'h14
`define SAM_REG_STAT      8'h18
`define SAM_REG_MASK      8'h1C
`define SAM_REG_FAULT     8'h20
// Bank config fields
`define SAM_BF_BASE_HI    12
`define SAM_BF_SIZE_LO    16
`define SAM_BF_WID_LO     20
`define SAM_BF_ALIGN      24
`define SAM_BF_EN         25
`define SAM_BANK_SHIFT    18
// Size codes: bank size is 256 KB shifted left by the code
`define SAM_SZ_SDRAM_MAX  4'h9
`define SAM_SZ_IO8_MAX    4'h4
`define SAM_SZ_IO16_MAX   4'h5
`define SAM_SZ_IO32_MAX   4'h6
`define SAM_WID_8         2'h0
`define SAM_WID_16        2'h1
`define SAM_WID_32        2'h2
// Reset values
`define SAM_ARB_RST       2'h0
`define SAM_BANK_RST      32'h0000_0000
`endif

// ---- sam_master_model.sv ----
// Far-side bus masters: hold requests until served, end each transfer
`timescale 1ns/1ps
module sam_master_model #(
    parameter N = 4
) (
    // Clock and reset
    input  wire          i_clk,
    input  wire          i_rst_n,
    // Test control
    input  wire  [N-1:0] i_want,
    input  wire  [3:0]   i_len,
    // Arbiter side
    input  wire  [N-1:0] i_gnt,
    output logic [N-1:0] o_req,
    output logic         o_done
);
    logic [3:0] cnt_q;
    wire        own = |(i_gnt & o_req);
    // Length 1 answers promptly, larger lengths keep the bus busy
    assign o_done = own && cnt_q == i_len - 4'h1;
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_req <= '0;
            cnt_q <= 4'h0;
        end else begin
            // Request stays up until the own transfer has ended
            o_req <= (o_req | i_want) & ~(o_done ? i_gnt & ~i_want : {N{1'b0}});
            cnt_q <= (o_done || !own) ? 4'h0 : cnt_q + 4'h1;
        end
    end
endmodule

// ---- sam_top.v ----
// System address decoder, external address generator and bus arbiters
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "sam_consts.vh"
module sam_top (
    // Clock and reset
    input  wire        I_SYS_CLK,
    input  wire        I_RST_N,
    // AHB-Lite register slave
    input  wire        I_HSEL,
    input  wire [31:0] I_HADDR,
    input  wire [1:0]  I_HTRANS,
    input  wire        I_HWRITE,
    input  wire [2:0]  I_HSIZE,
    input  wire [31:0] I_HWDATA,
    input  wire        I_HREADY,
    output wire [31:0] O_HRDATA,
    output wire        O_HREADYOUT,
    output wire        O_HRESP,
    // Interrupt
    output wire        O_IRQ,
    // Arbitration
    input  wire [3:0]  I_CPU_REQ,
    input  wire        I_CPU_XFER_DONE,
    output wire [3:0]  O_CPU_GNT,
    input  wire [7:0]  I_MST_REQ,
    input  wire        I_MST_XFER_DONE,
    output wire [7:0]  O_MST_GNT,
    // Address decode request
    input  wire        I_DEC_VALID,
    input  wire [31:0] I_DEC_ADDR,
    // Decode result
    output wire        O_DEC_DONE,
    output wire [4:0]  O_BANK_SEL,
    output wire [4:0]  O_PERI_SEL,
    output wire        O_ABORT,
    output wire        O_PERI_ERR,
    output wire [21:0] O_EXT_ADDR,
    output wire [31:0] O_BOOT_ADDR
);
    // Bank order: SDRAM 0, SDRAM 1, IO 0, IO 1, IO 2
    reg  [1:0]  arb_q;
    reg  [31:0] bank_q [0:4];
    reg  [1:0]  stat_q;
    reg  [1:0]  mask_q;
    reg  [31:0] fault_q;
    reg         wr_q;
    reg  [7:0]  wa_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg         done_q;
    reg  [4:0]  bank_sel_q;
    reg  [4:0]  peri_q;
    reg         abort_q;
    reg         perr_q;
    reg  [21:0] ext_q;
    reg  [31:0] boot_q;
    reg  [4:0]  hit;
    reg  [21:0] pins;
    integer     b;
    integer     r;

    // Size code a bank uses, capped at the largest it may use
    function [3:0] size_cap;
        input [2:0]  bank;
        input [31:0] cfg;
        reg   [3:0]  lim;
        begin
            if (bank < 3'h2) begin
                lim = `SAM_SZ_SDRAM_MAX;
            end else if (cfg[`SAM_BF_ALIGN]) begin
                lim = `SAM_SZ_IO8_MAX;
            end else if (cfg[`SAM_BF_WID_LO+1:`SAM_BF_WID_LO] == `SAM_WID_32) begin
                lim = `SAM_SZ_IO32_MAX;
            end else if (cfg[`SAM_BF_WID_LO+1:`SAM_BF_WID_LO] == `SAM_WID_16) begin
                lim = `SAM_SZ_IO16_MAX;
            end else begin
                lim = `SAM_SZ_IO8_MAX;
            end
            if (cfg[`SAM_BF_SIZE_LO+3:`SAM_BF_SIZE_LO] > lim) begin
                size_cap = lim;
            end else begin
                size_cap = cfg[`SAM_BF_SIZE_LO+3:`SAM_BF_SIZE_LO];
            end
        end
    endfunction

    // Address falls inside a programmed bank
    function bank_hit;
        input [2:0]  bank;
        input [31:0] cfg;
        input [31:0] addr;
        reg   [13:0] ofs;
        reg   [3:0]  sz;
        begin
            ofs = addr[31:`SAM_BANK_SHIFT] - {1'b0, cfg[`SAM_BF_BASE_HI:0]};
            sz  = size_cap(bank, cfg);
            bank_hit = cfg[`SAM_BF_EN]
                     & (addr[31:`SAM_BANK_SHIFT] >= {1'b0, cfg[`SAM_BF_BASE_HI:0]})
                     & ((ofs >> sz) == 14'h0000);
        end
    endfunction

    // Peripheral sub-window code, none for reserved holes
    function [4:0] peri_decode;
        input [31:0] a;
        begin
            peri_decode = `SAM_PS_NONE;
            if (a[31:16] == `SAM_PERI_BASE >> 16 && a[15:12] == 4'h0) begin
                if (a <= `SAM_GCR_LAST) begin
                    peri_decode = `SAM_PS_GCR;
                end else if (a >= `SAM_CLK_BASE && a <= `SAM_CLK_LAST) begin
                    peri_decode = `SAM_PS_CLK;
                end
            end else if (a[31:16] == `SAM_PERI_BASE >> 16) begin
                if (a[15:12] == 4'h1) begin
                    // Code 1 already names the control block, so this window takes a spare code
                    peri_decode = `SAM_PS_EBUS;
                end else if (a[15:12] != 4'h2 && a[15:12] != 4'hA && a[15:12] <= 4'hD) begin
                    peri_decode = {1'b0, a[15:12]};
                end
            end else if (a[31:16] == `SAM_HIGH_BASE >> 16) begin
                if (a[15:12] == 4'h0 && a[11:8] <= 4'h2) begin
                    peri_decode = {3'h4, a[9:8]};
                end else if (a[15:12] >= 4'h1 && a[15:12] <= 4'h3) begin
                    peri_decode = {3'h5, a[13:12]};
                end else if (a[15:12] == 4'h6 && a[11:8] <= 4'h2) begin
                    peri_decode = {3'h6, a[9:8]};
                end else if (a[15:12] == 4'h7 || a[15:12] == 4'h8) begin
                    peri_decode = {4'hE, a[15]};
                end
            end
        end
    endfunction

    // Decode of the incoming request
    wire        in_ext    = I_DEC_ADDR <= `SAM_EXT_LAST;
    wire        in_shadow = I_DEC_ADDR >= `SAM_SHADOW_BASE && I_DEC_ADDR <= `SAM_SHADOW_LAST;
    wire        in_peri   = I_DEC_ADDR >= `SAM_PERI_BASE && I_DEC_ADDR <= `SAM_PERI_LAST;
    // Shadow folds back onto the first 768 MB of external space
    wire [31:0] mem_addr  = in_shadow ? (I_DEC_ADDR - `SAM_SHADOW_BASE) : I_DEC_ADDR;
    wire [4:0]  peri_code = peri_decode(I_DEC_ADDR);

    // Bank hits and pin generation for the selected bank
    always @* begin
        hit  = 5'h00;
        pins = mem_addr[21:0];
        for (b = 0; b < 5; b = b + 1) begin
            hit[b] = (in_ext | in_shadow) & bank_hit(b[2:0], bank_q[b], mem_addr);
        end
        for (b = 4; b >= 0; b = b - 1) begin
            if (hit[b]) begin
                if (bank_q[b][`SAM_BF_ALIGN]) begin
                    pins = mem_addr[21:0];
                end else if (bank_q[b][`SAM_BF_WID_LO+1:`SAM_BF_WID_LO] == `SAM_WID_32) begin
                    pins = mem_addr[23:2];
                end else if (bank_q[b][`SAM_BF_WID_LO+1:`SAM_BF_WID_LO] == `SAM_WID_16) begin
                    pins = mem_addr[22:1];
                end else begin
                    pins = mem_addr[21:0];
                end
            end
        end
    end

    // Overlap is not flagged here: software keeps banks apart, lowest bank wins
    wire [4:0] hit_one = hit[0] ? 5'h01 : hit[1] ? 5'h02 : hit[2] ? 5'h04
                       : hit[3] ? 5'h08 : hit[4] ? 5'h10 : 5'h00;
    wire ev_abort = I_DEC_VALID & ~in_peri & (hit == 5'h00);
    wire ev_perr  = I_DEC_VALID & in_peri & (peri_code == `SAM_PS_NONE);

    always @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            done_q     <= 1'b0;
            bank_sel_q <= 5'h00;
            peri_q     <= `SAM_PS_NONE;
            abort_q    <= 1'b0;
            perr_q     <= 1'b0;
            ext_q      <= 22'h00_0000;
            boot_q     <= `SAM_BOOT_ADDR;
        end else begin
            done_q  <= I_DEC_VALID;
            abort_q <= ev_abort;
            perr_q  <= ev_perr;
            if (I_DEC_VALID) begin
                bank_sel_q <= in_peri ? 5'h00 : hit_one;
                peri_q     <= in_peri ? peri_code : `SAM_PS_NONE;
                ext_q      <= pins;
            end
        end
    end

    // AHB-Lite slave, zero wait states
    wire       acc  = I_HSEL & I_HTRANS[1] & I_HREADY;
    wire [7:0] roff = I_HADDR[7:0];

    always @* begin
        case (roff)
            `SAM_REG_ARB:   rdata_d = {30'h0000_0000, arb_q};
            `SAM_REG_SD0:   rdata_d = bank_q[0];
            `SAM_REG_SD1:   rdata_d = bank_q[1];
            `SAM_REG_IO0:   rdata_d = bank_q[2];
            `SAM_REG_IO1:   rdata_d = bank_q[3];
            `SAM_REG_IO2:   rdata_d = bank_q[4];
            `SAM_REG_STAT:  rdata_d = {30'h0000_0000, stat_q};
            `SAM_REG_MASK:  rdata_d = {30'h0000_0000, mask_q};
            `SAM_REG_FAULT: rdata_d = fault_q;
            default:        rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            wr_q    <= 1'b0;
            wa_q    <= 8'h00;
            rdata_q <= 32'h0000_0000;
            arb_q   <= `SAM_ARB_RST;
            mask_q  <= 2'h0;
            stat_q  <= 2'h0;
            fault_q <= 32'h0000_0000;
            for (r = 0; r < 5; r = r + 1) begin
                bank_q[r] <= `SAM_BANK_RST;
            end
        end else begin
            wr_q <= acc & I_HWRITE;
            wa_q <= roff;
            if (acc & ~I_HWRITE) begin
                rdata_q <= rdata_d;
            end
            if (wr_q) begin
                case (wa_q)
                    `SAM_REG_ARB:  arb_q     <= I_HWDATA[1:0];
                    `SAM_REG_SD0:  bank_q[0] <= I_HWDATA;
                    `SAM_REG_SD1:  bank_q[1] <= I_HWDATA;
                    `SAM_REG_IO0:  bank_q[2] <= I_HWDATA;
                    `SAM_REG_IO1:  bank_q[3] <= I_HWDATA;
                    `SAM_REG_IO2:  bank_q[4] <= I_HWDATA;
                    `SAM_REG_MASK: mask_q    <= I_HWDATA[1:0];
                    default:       mask_q    <= mask_q;
                endcase
            end
            // A new event beats a write-one clear in the same cycle
            stat_q <= (stat_q & ~((wr_q && wa_q == `SAM_REG_STAT) ? I_HWDATA[1:0] : 2'h0))
                    | {ev_perr, ev_abort};
            if (ev_abort | ev_perr) begin
                fault_q <= I_DEC_ADDR;
            end
        end
    end

    // Arbiters, bit 0 of the mode register for the CPU bus, bit 1 for the master bus
    sam_arb #(
        .N (4)
    ) u_cpu_arb (
        .i_clk       (I_SYS_CLK),
        .i_rst_n     (I_RST_N),
        .i_rotate    (arb_q[0]),
        .i_xfer_done (I_CPU_XFER_DONE),
        .i_req       (I_CPU_REQ),
        .o_gnt       (O_CPU_GNT)
    );

    sam_arb #(
        .N (8)
    ) u_mst_arb (
        .i_clk       (I_SYS_CLK),
        .i_rst_n     (I_RST_N),
        .i_rotate    (arb_q[1]),
        .i_xfer_done (I_MST_XFER_DONE),
        .i_req       (I_MST_REQ),
        .o_gnt       (O_MST_GNT)
    );

    assign O_HRDATA    = rdata_q;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP     = 1'b0;
    assign O_IRQ       = |(stat_q & mask_q);
    assign O_DEC_DONE  = done_q;
    assign O_BANK_SEL  = bank_sel_q;
    assign O_PERI_SEL  = peri_q;
    assign O_ABORT     = abort_q;
    assign O_PERI_ERR  = perr_q;
    assign O_EXT_ADDR  = ext_q;
    assign O_BOOT_ADDR = boot_q;
endmodule

// ---- sam_top_assertions.sv ----
// Port-level checks for the address decoder and bus arbiters
`timescale 1ns/1ps
module sam_top_assertions (
    // Clock and reset
    input wire        I_SYS_CLK,
    input wire        I_RST_N,
    // Decode
    input wire        I_DEC_VALID,
    input wire [31:0] I_DEC_ADDR,
    input wire        O_DEC_DONE,
    input wire [4:0]  O_BANK_SEL,
    input wire [4:0]  O_PERI_SEL,
    input wire        O_ABORT,
    input wire        O_PERI_ERR,
    input wire [31:0] O_BOOT_ADDR,
    // Arbiters
    input wire [3:0]  I_CPU_REQ,
    input wire        I_CPU_XFER_DONE,
    input wire [3:0]  O_CPU_GNT,
    input wire [7:0]  I_MST_REQ,
    input wire [7:0]  O_MST_GNT
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    sequence s_req; I_DEC_VALID; endsequence
    sequence s_ans; O_DEC_DONE; endsequence
    a_dec_answer: assert property (s_req |=> s_ans) else $error("decode answer missing");
    a_dec_cause: assert property (s_ans |-> $past(I_DEC_VALID)) else $error("decode answer without request");
    a_ext_no_peri: assert property (I_DEC_VALID && !I_DEC_ADDR[31] |=>
        O_PERI_SEL == 5'h00 && !O_PERI_ERR) else $error("external address hit a peripheral");
    a_peri_no_abort: assert property (I_DEC_VALID && I_DEC_ADDR[31:24] inside {[8'hB0:8'hBB]} |=>
        !O_ABORT && O_BANK_SEL == 5'h00) else $error("peripheral address aborted");
    a_abort_clean: assert property (O_ABORT |-> O_DEC_DONE && O_BANK_SEL == 5'h00
        && O_PERI_SEL == 5'h00) else $error("abort with a selection");
    a_err_no_sel: assert property (O_PERI_ERR |-> O_DEC_DONE && !O_ABORT
        && O_PERI_SEL == 5'h00) else $error("hole error with a selection");
    a_gnt_onehot: assert property ($onehot0(O_CPU_GNT) && $onehot0(O_MST_GNT)) else $error("grant not one-hot");
    a_cpu_hold: assert property (O_CPU_GNT != 4'h0 && !I_CPU_XFER_DONE && |(I_CPU_REQ & O_CPU_GNT)
        |=> $stable(O_CPU_GNT)) else $error("grant moved mid transfer");
    a_mst_serve: assert property (I_MST_REQ != 8'h00 && O_MST_GNT == 8'h00 |=>
        (O_MST_GNT & $past(I_MST_REQ)) != 8'h00) else $error("idle master bus not granted");
    a_boot_zero: assert property (O_BOOT_ADDR == 32'h0000_0000) else $error("boot address not zero");
endmodule
bind sam_top sam_top_assertions u_chk (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_DEC_VALID(I_DEC_VALID), .I_DEC_ADDR(I_DEC_ADDR),
    .O_DEC_DONE(O_DEC_DONE), .O_BANK_SEL(O_BANK_SEL), .O_PERI_SEL(O_PERI_SEL), .O_ABORT(O_ABORT),
    .O_PERI_ERR(O_PERI_ERR), .O_BOOT_ADDR(O_BOOT_ADDR), .I_CPU_REQ(I_CPU_REQ),
    .I_CPU_XFER_DONE(I_CPU_XFER_DONE), .O_CPU_GNT(O_CPU_GNT), .I_MST_REQ(I_MST_REQ), .O_MST_GNT(O_MST_GNT));

// ---- sam_top_tb.sv ----
// Self-checking bench for the address map, pin address and arbiters
`timescale 1ns/1ps
module sam_top_tb;
    typedef struct packed {logic [31:0] a; logic [4:0] b; logic [4:0] p; logic [1:0] f; logic [21:0] e;} sam_row_t;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, dv = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, da = 32'h0000_0000, rd;
    logic [1:0]  htrans = 2'h0;
    logic [3:0]  wc = 4'h0, lc = 4'h5, lm = 4'h1;
    logic [7:0]  wm = 8'h00;
    logic [31:0] lgc = 32'h0000_0000, lgm = 32'h0000_0000, hrdata, boot;
    int          nc = 0, nm = 0, bad_count = 0, tests_run = 0;
    wire         hready, hresp, irq, cdone, mdone, done, abort, perr;
    wire [3:0]   creq, cgnt;
    wire [7:0]   mreq, mgnt;
    wire [4:0]   bsel, psel;
    wire [21:0]  ext;
    // Pattern f is {abort, hole error}; p is the expected peripheral code
    sam_row_t rows [0:17] = '{
        '{32'h0000_0100, 5'h01, 5'h00, 2'h0, 22'h00_0100}, '{32'h07FF_FFFC, 5'h01, 5'h00, 2'h0, 22'h3F_FFFC},
        '{32'h0800_0000, 5'h00, 5'h00, 2'h2, 22'h00_0000}, '{32'h1000_0246, 5'h04, 5'h00, 2'h0, 22'h00_0123},
        '{32'h107F_FFFE, 5'h04, 5'h00, 2'h0, 22'h3F_FFFF}, '{32'h1080_0000, 5'h00, 5'h00, 2'h2, 22'h00_0000},
        '{32'h2000_0347, 5'h08, 5'h00, 2'h0, 22'h00_0347}, '{32'h2040_0000, 5'h00, 5'h00, 2'h2, 22'h00_0000},
        '{32'h8000_0100, 5'h01, 5'h00, 2'h0, 22'h00_0100}, '{32'h8800_0000, 5'h00, 5'h00, 2'h2, 22'h00_0000},
        '{32'hB000_0000, 5'h00, 5'h01, 2'h0, 22'h00_0000}, '{32'hB000_0200, 5'h00, 5'h02, 2'h0, 22'h00_0000},
        '{32'hB000_1000, 5'h00, 5'h0F, 2'h0, 22'h00_0000}, '{32'hB800_0100, 5'h00, 5'h11, 2'h0, 22'h00_0000},
        '{32'hB000_A000, 5'h00, 5'h00, 2'h1, 22'h00_0000}, '{32'hBC00_0000, 5'h00, 5'h00, 2'h2, 22'h00_0000},
        '{32'hB800_2000, 5'h00, 5'h16, 2'h0, 22'h00_0000}, '{32'hB800_0300, 5'h00, 5'h00, 2'h1, 22'h00_0000}};

    sam_top dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .O_IRQ(irq), .I_CPU_REQ(creq), .I_CPU_XFER_DONE(cdone),
        .O_CPU_GNT(cgnt), .I_MST_REQ(mreq), .I_MST_XFER_DONE(mdone), .O_MST_GNT(mgnt), .I_DEC_VALID(dv),
        .I_DEC_ADDR(da), .O_DEC_DONE(done), .O_BANK_SEL(bsel), .O_PERI_SEL(psel), .O_ABORT(abort),
        .O_PERI_ERR(perr), .O_EXT_ADDR(ext), .O_BOOT_ADDR(boot));
    sam_master_model #(.N(4)) u_cpu (.i_clk(clk), .i_rst_n(rst_n), .i_want(wc), .i_len(lc), .i_gnt(cgnt),
        .o_req(creq), .o_done(cdone));
    sam_master_model #(.N(8)) u_mst (.i_clk(clk), .i_rst_n(rst_n), .i_want(wm), .i_len(lm), .i_gnt(mgnt),
        .o_req(mreq), .o_done(mdone));

    always #50 clk = ~clk;

    function automatic logic [3:0] enc(input logic [7:0] g);
        enc = 4'hF;
        for (int i = 0; i < 8; i++) if (g[i]) enc = i[3:0];
    endfunction
    // Served masters in order, newest in the low nibble
    always @(posedge clk) begin
        if (cdone) begin
            lgc <= {lgc[27:0], enc({4'h0, cgnt})};
            nc <= nc + 1;
        end
        if (mdone) begin
            lgm <= {lgm[27:0], enc(mgnt)};
            nm <= nm + 1;
        end
    end

    task end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task tmo;
        bad_count++;
        $display("timeout at %0t", $time);
        end_of_test;
    endtask
    task rdy;
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (hready !== 1'b1 && i < 20);
        if (hready !== 1'b1) tmo;
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        hsel <= 1'b1;
        htrans <= 2'h2;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        rd = hrdata;
        #1;
    endtask
    task dec(input logic [31:0] a);
        dv <= 1'b1;
        da <= a;
        @(posedge clk);
        dv <= 1'b0;
        #1;
    endtask
    task irqc(input logic x);
        @(posedge clk);
        #1;
        chk(irq, x);
    endtask
    task wdone(input int tc, input int tm);
        int i;
        for (i = 0; i < 400 && (nc < tc || nm < tm); i++) @(posedge clk);
        if (i == 400) tmo;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({cgnt, mgnt}, 32'h0000_0000);
        chk(boot, 32'h0000_0000);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // Banks kept apart: 0-128M, 256M+8M, 512M+4M
        ahb(1'b1, 32'h0000_0004, 32'h0209_0000);
        ahb(1'b1, 32'h0000_000C, 32'h0215_0400);
        ahb(1'b1, 32'h0000_0010, 32'h0326_0800);
        ahb(1'b0, 32'h0000_000C, 32'h0000_0000);
        chk(rd, 32'h0215_0400);
        ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h0000_0040, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        foreach (rows[k]) begin
            dec(rows[k].a);
            chk(done, 1'b1);
            chk(bsel, rows[k].b);
            chk({abort, perr}, rows[k].f);
            chk(psel, rows[k].p);
            if (rows[k].b != 5'h00) chk(ext, rows[k].e);
        end
        ahb(1'b0, 32'h0000_0018, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        irqc(1'b0);
        ahb(1'b1, 32'h0000_001C, 32'h0000_0001);
        irqc(1'b1);
        ahb(1'b1, 32'h0000_0018, 32'h0000_0001);
        irqc(1'b0);
        ahb(1'b0, 32'h0000_0018, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        ahb(1'b1, 32'h0000_001C, 32'h0000_0002);
        irqc(1'b1);
        ahb(1'b1, 32'h0000_0018, 32'h0000_0002);
        irqc(1'b0);
        // All masters at once: fixed order, slow CPU bus, prompt master bus
        wc <= 4'hF;
        wm <= 8'hFF;
        @(posedge clk);
        wc <= 4'h0;
        wm <= 8'h00;
        wdone(4, 8);
        chk(lgc[15:0], 16'h3210);
        chk(lgm, 32'h7654_3210);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0003);
        lc <= 4'h2;
        wc <= 4'h9;
        wdone(8, 8);
        wc <= 4'h0;
        chk(lgc[15:0], 16'h3030);
        wm <= 8'h42;
        wdone(8, 12);
        wm <= 8'h00;
        chk(lgm[15:0], 16'h1616);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(boot, 32'h0000_0000);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        end_of_test;
    end
endmodule
